// >>> flash_access_ctrl.sv
`timescale 1ns/100ps
module flash_access_ctrl (
	input  wire logic                            ref_clk_in,
	input  wire logic                            reset_n_in,
	input  wire logic                            tool_socket_in,
	input  wire logic                            prog_select_voltage_in,
	input  wire logic                            tool_present_in,
	input  wire logic                            prog_serial_clock_in,
	input  wire logic                            prog_serial_data_in,
	output logic                                 prog_serial_data_out,
	output logic                                 prog_serial_data_oe_out,
	input  wire logic                            req_valid_in,
	input  wire flash_access_pkg::op_t           req_op_in,
	input  wire logic [15:0]                     req_addr_in,
	input  wire logic [7:0]                      req_data_in,
	output logic                                 req_ready_out,
	output logic                                 req_done_out,
	output logic                                 req_refused_out,
	input  wire logic [15:0]                     rd_addr_in,
	input  wire logic                            rd_external_in,
	output logic [7:0]                           rd_data_out,
	output logic                                 ram_wr_out,
	output logic [flash_access_pkg::RAM_AW-1:0]  ram_addr_out,
	output logic [7:0]                           ram_data_out,
	output flash_access_pkg::mode_t              mode_out,
	output logic                                 mode_valid_out,
	output logic                                 incircuit_comm_mode_out,
	output logic                                 readout_protect_option_out,
	output logic                                 low_voltage_detector_en_out,
	output logic                                 app_pins_free_out
);
	import flash_access_pkg::*;

	typedef enum logic {
		ST_IDLE,
		ST_ERASE
	} st_t;

	typedef struct packed {
		st_t                st;
		logic [13:0]        ptr;
		logic [13:0]        last;
		logic               opt_pend;
		logic [7:0]         opt_new;
		logic [7:0]         opt;
		logic [1:0]         key;
		mode_t              mode;
		logic               mode_ok;
		logic [1:0]         settle;
		logic [2:0]         sel_s;
		logic [2:0]         sock_s;
		logic [2:0]         tool_s;
		logic [2:0]         tgl_s;
		logic               sel_st;
		logic               sock_st;
		logic               tool_st;
		logic               tgl_acc;
		logic               done;
		logic               refused;
		logic               ram_wr;
		logic [RAM_AW-1:0]  ram_ptr;
		logic [RAM_AW-1:0]  ram_addr;
		logic [7:0]         ram_data;
		logic [7:0]         rd_data;
		logic               wr_en;
		logic [13:0]        wr_idx;
		logic [7:0]         wr_data;
	} state_t;

	state_t q;
	state_t d;

	logic [7:0] mem [0:(1<<FLASH_AW)-1];

	link_if lnk ();

	link_rx u_link (
		.prog_serial_clock_in    (prog_serial_clock_in),
		.prog_serial_data_in     (prog_serial_data_in),
		.prog_serial_data_out    (prog_serial_data_out),
		.prog_serial_data_oe_out (prog_serial_data_oe_out),
		.lnk                     (lnk)
	);

	function automatic sect_t sector_of(input logic [15:0] addr);
		if (addr >= SECT0_BASE) begin
			return SECT_0;
		end else if (addr >= SECT1_BASE) begin
			return SECT_1;
		end else if (addr >= FLASH_BASE) begin
			return SECT_2;
		end else begin
			return SECT_NONE;
		end
	endfunction : sector_of

	// application mode may touch neither sector 0 nor the option byte
	function automatic logic permitted(input mode_t m, input op_t op, input logic [15:0] addr);
		logic ok;
		ok = 1'b1;
		if ((op == OP_PROG || op == OP_ERASE_SECT) && sector_of(addr) == SECT_NONE) begin
			ok = 1'b0;
		end
		if (m == MODE_IAP) begin
			if (op == OP_OPTION || op == OP_ERASE_ALL) begin
				ok = 1'b0;
			end
			if (sector_of(addr) == SECT_0) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : permitted

	assign lnk.enable = q.mode_ok && (q.mode == MODE_ICP);

	always_comb begin
		d         = q;
		d.done    = 1'b0;
		d.refused = 1'b0;
		d.ram_wr  = 1'b0;
		d.wr_en   = 1'b0;

		// first stage feeds only the second; change counts once the last two agree
		d.sel_s  = {q.sel_s[1:0], prog_select_voltage_in};
		d.sock_s = {q.sock_s[1:0], tool_socket_in};
		d.tool_s = {q.tool_s[1:0], tool_present_in};
		d.tgl_s  = {q.tgl_s[1:0], lnk.rx_tgl};
		if (q.sel_s[1] == q.sel_s[2]) begin
			d.sel_st = q.sel_s[2];
		end
		if (q.sock_s[1] == q.sock_s[2]) begin
			d.sock_st = q.sock_s[2];
		end
		if (q.tool_s[1] == q.tool_s[2]) begin
			d.tool_st = q.tool_s[2];
		end

		// mode is latched once pins settle after reset release
		if (!q.mode_ok) begin
			if (q.settle == SYNC_SETTLE) begin
				d.mode_ok = 1'b1;
				// filtered levels of this edge: the registered ones lag one cycle
				if (d.sock_st) begin
					d.mode = MODE_TOOL;
				end else if (d.sel_st) begin
					d.mode = MODE_ICP;
				end else begin
					d.mode = MODE_IAP;
				end
			end else begin
				d.settle = q.settle + 2'h1;
			end
		end

		// bytes from the link land in RAM for downloaded code or test patterns
		if (!lnk.enable) begin
			d.tgl_acc = q.tgl_s[2];
			d.ram_ptr = '0;
		end else if (q.tgl_s[1] == q.tgl_s[2] && q.tgl_s[2] != q.tgl_acc) begin
			d.tgl_acc  = q.tgl_s[2];
			d.ram_wr   = 1'b1;
			d.ram_addr = q.ram_ptr;
			d.ram_data = lnk.rx_byte;
			d.ram_ptr  = q.ram_ptr + 1'b1;
		end

		// external reads are blanked while protected
		if (sector_of(rd_addr_in) == SECT_NONE) begin
			d.rd_data = PROTECTED_RD;
		end else if (q.opt[ROP_BIT] && rd_external_in) begin
			d.rd_data = PROTECTED_RD;
		end else begin
			d.rd_data = mem[rd_addr_in[FLASH_AW-1:0]];
		end

		unique case (q.st)
			ST_IDLE: begin
				if (req_valid_in && q.mode_ok) begin
					if (req_op_in == OP_KEY) begin
						d.done = 1'b1;
						if (req_data_in == GUARD_KEY1) begin
							d.key = 2'h1;
						end else if (q.key == 2'h1 && req_data_in == GUARD_KEY2) begin
							d.key = 2'h2;
						end else begin
							d.key = 2'h0;
						end
					end else begin
						d.key = 2'h0;
						if (q.key != 2'h2) begin
							d.refused = 1'b1;
						end else if (!permitted(q.mode, req_op_in, req_addr_in)) begin
							d.refused = 1'b1;
						end else begin
							case (req_op_in)
								OP_PROG: begin
									d.wr_en   = 1'b1;
									d.wr_idx  = req_addr_in[FLASH_AW-1:0];
									d.wr_data = req_data_in;
									d.done    = 1'b1;
								end
								OP_ERASE_SECT: begin
									d.st = ST_ERASE;
									unique case (sector_of(req_addr_in))
										SECT_0: begin
											d.ptr  = SECT0_LO;
											d.last = SECT0_HI;
										end
										SECT_1: begin
											d.ptr  = SECT1_LO;
											d.last = SECT1_HI;
										end
										SECT_2: begin
											d.ptr  = SECT2_LO;
											d.last = SECT2_HI;
										end
										SECT_NONE: begin
											d.st = ST_IDLE;
										end
									endcase
								end
								OP_ERASE_ALL: begin
									d.st   = ST_ERASE;
									d.ptr  = SECT2_LO;
									d.last = SECT0_HI;
								end
								OP_OPTION: begin
									if (q.opt[ROP_BIT] && !req_data_in[ROP_BIT]) begin
										d.st       = ST_ERASE;
										d.ptr      = SECT2_LO;
										d.last     = SECT0_HI;
										d.opt_pend = 1'b1;
										d.opt_new  = req_data_in;
									end else begin
										d.opt  = req_data_in;
										d.done = 1'b1;
									end
								end
								default: begin
									d.refused = 1'b1;
								end
							endcase
						end
					end
				end
			end
			ST_ERASE: begin
				// one byte per cycle keeps the array write port single
				d.wr_en   = 1'b1;
				d.wr_idx  = q.ptr;
				d.wr_data = ERASED_BYTE;
				if (q.ptr == q.last) begin
					d.st   = ST_IDLE;
					d.done = 1'b1;
					if (q.opt_pend) begin
						d.opt      = q.opt_new;
						d.opt_pend = 1'b0;
					end
				end else begin
					d.ptr = q.ptr + 14'h1;
				end
			end
		endcase
	end

	// option byte is reloaded from its default at reset; no nonvolatile copy here
	always_ff @(posedge ref_clk_in) begin
		if (!reset_n_in) begin
			q     <= '0;
			q.opt <= OPT_RESET;
		end else begin
			q <= d;
		end
	end

	// array itself is not reset: its contents are nonvolatile
	always_ff @(posedge ref_clk_in) begin
		if (q.wr_en) begin
			mem[q.wr_idx] <= q.wr_data;
		end
	end

	assign req_ready_out               = (q.st == ST_IDLE) && q.mode_ok;
	assign req_done_out                = q.done;
	assign req_refused_out             = q.refused;
	assign rd_data_out                 = q.rd_data;
	assign ram_wr_out                  = q.ram_wr;
	assign ram_addr_out                = q.ram_addr;
	assign ram_data_out                = q.ram_data;
	assign mode_out                    = q.mode;
	assign mode_valid_out              = q.mode_ok;
	assign incircuit_comm_mode_out     = q.mode_ok && (q.mode == MODE_ICP);
	assign readout_protect_option_out  = q.opt[ROP_BIT];
	assign low_voltage_detector_en_out = q.opt[LVD_BIT] && !q.opt[ROP_BIT];
	assign app_pins_free_out           = !q.tool_st;

endmodule : flash_access_ctrl

// >>> flash_access_pkg.sv
package flash_access_pkg;

	localparam int          FLASH_AW      = 14;
	localparam int          RAM_AW        = 11;
	localparam logic [15:0] FLASH_BASE    = 16'hc000;
	localparam logic [15:0] SECT1_BASE    = 16'he000;
	localparam logic [15:0] SECT0_BASE    = 16'hf000;
	localparam logic [13:0] SECT0_LO      = 14'h3000;
	localparam logic [13:0] SECT0_HI      = 14'h3fff;
	localparam logic [13:0] SECT1_LO      = 14'h2000;
	localparam logic [13:0] SECT1_HI      = 14'h2fff;
	localparam logic [13:0] SECT2_LO      = 14'h0000;
	localparam logic [13:0] SECT2_HI      = 14'h1fff;
	localparam logic [7:0]  ERASED_BYTE   = 8'hff;
	localparam logic [7:0]  GUARD_KEY1    = 8'h56;
	localparam logic [7:0]  GUARD_KEY2    = 8'hae;
	localparam int          ROP_BIT       = 0;
	localparam int          LVD_BIT       = 1;
	localparam logic [7:0]  OPT_RESET     = 8'h02;
	localparam logic [1:0]  SYNC_SETTLE   = 2'h3;
	localparam logic [7:0]  PROTECTED_RD  = 8'h00;

	typedef enum logic [2:0] {
		OP_KEY,
		OP_PROG,
		OP_ERASE_SECT,
		OP_ERASE_ALL,
		OP_OPTION
	} op_t;

	typedef enum logic [1:0] {
		MODE_TOOL,
		MODE_ICP,
		MODE_IAP
	} mode_t;

	typedef enum logic [1:0] {
		SECT_0,
		SECT_1,
		SECT_2,
		SECT_NONE
	} sect_t;

endpackage : flash_access_pkg

// >>> link_if.sv
`timescale 1ns/100ps
interface link_if;
	logic       enable;
	logic [7:0] rx_byte;
	logic       rx_tgl;

	modport link (
		input  enable,
		output rx_byte,
		output rx_tgl
	);

	modport core (
		output enable,
		input  rx_byte,
		input  rx_tgl
	);
endinterface : link_if

// >>> link_rx.sv
`timescale 1ns/100ps
module link_rx (
	input  wire logic prog_serial_clock_in,
	input  wire logic prog_serial_data_in,
	output logic      prog_serial_data_out,
	output logic      prog_serial_data_oe_out,
	link_if.link      lnk
);
	typedef struct packed {
		logic       en_s0;
		logic       en_s1;
		logic [7:0] shift;
		logic [2:0] cnt;
		logic       ack;
		logic [7:0] rx_byte;
		logic       tgl;
	} lstate_t;

	lstate_t q;
	lstate_t d;

	// clock only runs inside frames; disabled state is reached on the third edge after enable drops
	always_comb begin
		d       = q;
		d.en_s0 = lnk.enable;
		d.en_s1 = q.en_s0;
		d.ack   = 1'b0;
		if (!q.en_s1) begin
			d.cnt     = 3'h0;
			d.shift   = 8'h00;
			d.rx_byte = 8'h00;
			d.tgl     = 1'b0;
		end else if (!q.ack) begin
			// the ack slot clock carries no data, so bytes stay aligned
			d.shift = {q.shift[6:0], prog_serial_data_in};
			d.cnt   = q.cnt + 3'h1;
			if (q.cnt == 3'h7) begin
				d.rx_byte = {q.shift[6:0], prog_serial_data_in};
				d.tgl     = ~q.tgl;
				d.ack     = 1'b1;
			end
		end
	end

	always_ff @(posedge prog_serial_clock_in) begin
		q <= d;
	end

	// open-drain style ack: pulled low for one bit after each byte
	assign prog_serial_data_out    = 1'b0;
	assign prog_serial_data_oe_out = q.ack;
	assign lnk.rx_byte             = q.rx_byte;
	assign lnk.rx_tgl              = q.tgl;

endmodule : link_rx

// >>> flash_access_checker.sv
`timescale 1ns/100ps
module flash_access_checker import flash_access_pkg::*; (
	input wire logic                    ref_clk_in,
	input wire logic                    reset_n_in,
	input wire logic                    tool_present_in,
	input wire logic                    prog_serial_clock_in,
	input wire logic                    prog_serial_data_out,
	input wire logic                    prog_serial_data_oe_out,
	input wire logic                    req_valid_in,
	input wire flash_access_pkg::op_t   req_op_in,
	input wire logic [15:0]             req_addr_in,
	input wire logic [7:0]              req_data_in,
	input wire logic                    req_ready_out,
	input wire logic                    req_done_out,
	input wire logic                    req_refused_out,
	input wire logic                    rd_external_in,
	input wire logic [7:0]              rd_data_out,
	input wire logic                    ram_wr_out,
	input wire flash_access_pkg::mode_t mode_out,
	input wire logic                    incircuit_comm_mode_out,
	input wire logic                    readout_protect_option_out,
	input wire logic                    low_voltage_detector_en_out,
	input wire logic                    app_pins_free_out
);
	logic take, k1_q, k1_d, arm_q, arm_d;
	assign take = req_valid_in && req_ready_out;
	// key pair tracked from taken requests only
	always_comb begin
		k1_d = k1_q;
		arm_d = arm_q;
		if (take) begin
			k1_d = req_op_in == OP_KEY && req_data_in == GUARD_KEY1;
			arm_d = req_op_in == OP_KEY && req_data_in == GUARD_KEY2 && k1_q;
		end
	end
	always_ff @(posedge ref_clk_in) begin
		k1_q <= reset_n_in && k1_d;
		arm_q <= reset_n_in && arm_d;
	end
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_req(op_t o);
		take && req_op_in == o;
	endsequence
	sequence s_armed_op;
		take && arm_q && req_op_in != OP_KEY;
	endsequence
	property p_guard;
		take && !arm_q && req_op_in != OP_KEY |=> req_refused_out && !req_done_out;
	endproperty
	property p_key;
		s_req(OP_KEY) ##0 req_data_in == GUARD_KEY1 |=> req_done_out;
	endproperty
	property p_app_s0;
		s_armed_op ##0 (mode_out == MODE_IAP && req_addr_in[15:12] == 4'hf) |=> req_refused_out;
	endproperty
	property p_prog;
		s_req(OP_PROG) ##0 (arm_q && mode_out != MODE_IAP && req_addr_in >= FLASH_BASE) |=> req_done_out;
	endproperty
	property p_erase;
		s_armed_op ##0 (req_op_in == OP_ERASE_SECT && req_addr_in[15:12] == 4'he) |=> !req_ready_out [*8];
	endproperty
	property p_lvd;
		readout_protect_option_out |-> !low_voltage_detector_en_out;
	endproperty
	property p_pins;
		(tool_present_in && reset_n_in) [*6] |=> !app_pins_free_out;
	endproperty
	property p_read;
		rd_external_in && readout_protect_option_out |=> rd_data_out == PROTECTED_RD;
	endproperty
	property p_ram;
		ram_wr_out |-> incircuit_comm_mode_out;
	endproperty
	property p_ack;
		prog_serial_data_oe_out |-> !prog_serial_data_out;
	endproperty
	// link clock stops between frames, so this one counts link edges only
	property p_oe;
		@(posedge prog_serial_clock_in) disable iff (!incircuit_comm_mode_out)
		$rose(prog_serial_data_oe_out) |=> !prog_serial_data_oe_out;
	endproperty
	a_guard: assert property (p_guard) else $error("unarmed request not refused");
	a_key: assert property (p_key) else $error("first key not done");
	a_app_s0: assert property (p_app_s0) else $error("sector 0 change in app mode");
	a_prog: assert property (p_prog) else $error("program not done");
	a_erase: assert property (p_erase) else $error("sector erase too short");
	a_lvd: assert property (p_lvd) else $error("detector on while protected");
	a_pins: assert property (p_pins) else $error("pins free with tool present");
	a_read: assert property (p_read) else $error("protected data leaked");
	a_ram: assert property (p_ram) else $error("ram write outside link mode");
	a_ack: assert property (p_ack) else $error("ack level not low");
	a_oe: assert property (p_oe) else $error("ack longer than one link clock");
endmodule : flash_access_checker
bind flash_access_ctrl flash_access_checker chk_u (.*);

// >>> link_tool_model.sv
`timescale 1ns/100ps
module link_tool_model (
	output logic      prog_serial_clock_out,
	output logic      data_drive_out,
	input  wire logic line_in
);
	initial begin
		prog_serial_clock_out = 1'b0;
		data_drive_out = 1'b1;
	end
	task pulses(input int c);
		begin
			repeat (c) begin
				#15 prog_serial_clock_out = 1'b1;
				#15 prog_serial_clock_out = 1'b0;
			end
		end
	endtask : pulses
	task frame(input logic [7:0] b, output logic ack);
		int i;
		begin
			#7;
			pulses(2);
			for (i = 7; i >= 0; i--) begin
				data_drive_out = b[i];
				pulses(1);
			end
			// released, so the pull-up shows unless the device acks
			data_drive_out = 1'b1;
			// ack stands from the eighth rise to the ninth, so look before the ninth
			#7 ack = !line_in;
			#8 prog_serial_clock_out = 1'b1;
			#15 prog_serial_clock_out = 1'b0;
		end
	endtask : frame
endmodule : link_tool_model

// >>> testbench.sv
`timescale 1ns/100ps
`define CHK(g, e) check(16'(g), 16'(e))
module testbench;
	import flash_access_pkg::*;
	typedef struct packed {op_t o; logic [15:0] a; logic [7:0] d; logic r;} row_t;
	logic              clk = 1'b0, rst_n = 1'b0, socket = 1'b0, sel = 1'b0, present = 1'b0;
	logic              valid = 1'b0, rd_ext = 1'b0, lclk, tdrv, line, sd_o, sd_oe, ack;
	logic              ready, done, refused, ram_wr, mv, incircuit_comm_mode, rop, low_voltage_detector, free;
	op_t               op = OP_KEY;
	logic [15:0]       addr = 16'h0000, rd_addr = 16'h0000;
	logic [7:0]        data = 8'h00, rd_data, ram_d;
	logic [RAM_AW-1:0] ram_a;
	mode_t             mode;
	int                num_errors = 0, cmp_count = 0;
	row_t              rows [7];
	flash_access_ctrl dut_u (.ref_clk_in(clk), .reset_n_in(rst_n), .tool_socket_in(socket),
		.prog_select_voltage_in(sel), .tool_present_in(present), .prog_serial_clock_in(lclk),
		.prog_serial_data_in(line), .prog_serial_data_out(sd_o), .prog_serial_data_oe_out(sd_oe),
		.req_valid_in(valid), .req_op_in(op), .req_addr_in(addr), .req_data_in(data),
		.req_ready_out(ready), .req_done_out(done), .req_refused_out(refused), .rd_addr_in(rd_addr),
		.rd_external_in(rd_ext), .rd_data_out(rd_data), .ram_wr_out(ram_wr), .ram_addr_out(ram_a),
		.ram_data_out(ram_d), .mode_out(mode), .mode_valid_out(mv), .incircuit_comm_mode_out(incircuit_comm_mode),
		.readout_protect_option_out(rop), .low_voltage_detector_en_out(low_voltage_detector), .app_pins_free_out(free));
	link_tool_model tool_u (.prog_serial_clock_out(lclk), .data_drive_out(tdrv), .line_in(line));
	assign line = tdrv && !(sd_oe && !sd_o);
	always #25 clk = ~clk;
	task conclude;
		begin
			if (num_errors == 0 && cmp_count > 0) begin
				$display("ALL CHECKS OK");
			end else begin
				$display("CHECKS NOT OK");
			end
			$finish;
		end
	endtask : conclude
	task give_up;
		begin
			num_errors++;
			conclude();
		end
	endtask : give_up
	task check(input logic [15:0] g, input logic [15:0] e);
		begin
			cmp_count++;
			if (g !== e) begin
				num_errors++;
				$display("unexpected at %0t: got %h, expected %h", $time, g, e);
			end
		end
	endtask : check
	task rst(input logic s, input logic p, input logic t);
		int k;
		begin
			@(posedge clk);
			rst_n <= 1'b0;
			socket <= s;
			sel <= p;
			present <= t;
			// link logic only clears on its own clock
			tool_u.pulses(4);
			repeat (12) @(posedge clk);
			`CHK(mv, 1'b0);
			`CHK(rop, 1'b0);
			`CHK(low_voltage_detector, 1'b1);
			rst_n <= 1'b1;
			k = 0;
			@(posedge clk);
			while (ready !== 1'b1) begin
				if (++k > 40) give_up();
				@(posedge clk);
			end
		end
	endtask : rst
	task req(input op_t o, input logic [15:0] a, input logic [7:0] d, input logic r);
		int k;
		begin
			k = 0;
			@(posedge clk);
			while (ready !== 1'b1) begin
				if (++k > 20000) give_up();
				@(posedge clk);
			end
			valid <= 1'b1;
			op <= o;
			addr <= a;
			data <= d;
			@(posedge clk);
			valid <= 1'b0;
			k = 0;
			do begin
				@(posedge clk);
				if (++k > 20000) give_up();
			end while (done !== 1'b1 && refused !== 1'b1);
			`CHK(refused, r);
		end
	endtask : req
	task keyed(input op_t o, input logic [15:0] a, input logic [7:0] d, input logic r);
		begin
			req(OP_KEY, 16'h0000, GUARD_KEY1, 1'b0);
			req(OP_KEY, 16'h0000, GUARD_KEY2, 1'b0);
			req(o, a, d, r);
		end
	endtask : keyed
	task rdc(input logic [15:0] a, input logic e, input logic [7:0] x);
		begin
			@(posedge clk);
			rd_addr <= a;
			rd_ext <= e;
			repeat (2) @(posedge clk);
			`CHK(rd_data, x);
		end
	endtask : rdc
	task ram_wait(input logic [7:0] d);
		int k;
		begin
			k = 0;
			while (ram_wr !== 1'b1) begin
				if (++k > 40) give_up();
				@(posedge clk);
			end
			`CHK(ram_a, 0);
			`CHK(ram_d, d);
		end
	endtask : ram_wait
	initial begin
		rows = '{'{OP_PROG, 16'he000, 8'h11, 1'b0}, '{OP_PROG, 16'hc000, 8'h22, 1'b0},
			'{OP_PROG, 16'hf000, 8'h33, 1'b1}, '{OP_ERASE_SECT, 16'hf800, 8'h00, 1'b1},
			'{OP_ERASE_ALL, 16'hc000, 8'h00, 1'b1}, '{OP_OPTION, 16'h0000, 8'h03, 1'b1},
			'{OP_PROG, 16'h8000, 8'h44, 1'b1}};
		rst(1'b0, 1'b1, 1'b1);
		`CHK(mode, MODE_ICP);
		`CHK(incircuit_comm_mode, 1'b1);
		fork
			tool_u.frame(8'h3c, ack);
			ram_wait(8'h3c);
		join
		`CHK(ack, 1'b1);
		`CHK(free, 1'b0);
		keyed(OP_OPTION, 16'h0000, 8'h03, 1'b0);
		`CHK(rop, 1'b1);
		`CHK(low_voltage_detector, 1'b0);
		rdc(16'hf000, 1'b1, PROTECTED_RD);
		keyed(OP_OPTION, 16'h0000, OPT_RESET, 1'b0);
		`CHK(rop, 1'b0);
		rdc(16'hc000, 1'b1, ERASED_BYTE);
		keyed(OP_PROG, 16'hf000, 8'ha5, 1'b0);
		rst(1'b0, 1'b0, 1'b0);
		`CHK(mode, MODE_IAP);
		`CHK(free, 1'b1);
		foreach (rows[i]) begin
			keyed(rows[i].o, rows[i].a, rows[i].d, rows[i].r);
		end
		req(OP_PROG, 16'he001, 8'h55, 1'b1);
		rdc(16'hf000, 1'b0, 8'ha5);
		rdc(16'he000, 1'b0, 8'h11);
		keyed(OP_ERASE_SECT, 16'he800, 8'h00, 1'b0);
		rdc(16'he000, 1'b0, ERASED_BYTE);
		rdc(16'hc000, 1'b0, 8'h22);
		rst(1'b1, 1'b0, 1'b0);
		`CHK(mode, MODE_TOOL);
		keyed(OP_PROG, 16'hf001, 8'h5a, 1'b0);
		rdc(16'hf001, 1'b0, 8'h5a);
		conclude();
	end
endmodule : testbench
